// *** sfsc_pkg.sv ***
// Package with opcodes, status bit positions and timing constants for the serial flash link
package sfsc_pkg;
  // Instruction codes
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FREAD = 8'h0b;
  localparam logic [7:0] OP_DREAD = 8'h3b;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_BERASE = 8'hd8;
  localparam logic [7:0] OP_SERASE = 8'h20;
  localparam logic [7:0] OP_CERASE = 8'hc7;
  localparam logic [7:0] OP_PDOWN = 8'hb9;
  localparam logic [7:0] OP_RELID = 8'hab;
  localparam logic [7:0] OP_MFID = 8'h90;
  localparam logic [7:0] OP_JEDID = 8'h9f;
  // Status bit positions
  localparam int SB_BUSY = 0;
  localparam int SB_WEL = 1;
  localparam int SB_BP0 = 2;
  localparam int SB_BP1 = 3;
  localparam int SB_BP2 = 4;
  localparam int SB_TB = 5;
  localparam int SB_SRP = 7;
  // Writable status bits 7,5,4,3,2
  localparam logic [7:0] SR_WMASK = 8'hbc;
  localparam logic [7:0] SR_RESET = 8'h00;
  // Arbitrary identity values
  localparam logic [7:0] ID_MFR = 8'h5a;
  localparam logic [7:0] ID_DEV = 8'h21;
  localparam logic [7:0] ID_TYPE = 8'h42;
  // Self-timed cycle times in ns, and clock period in ns
  localparam int CLK_NS = 8;
  localparam int TW_NS = 10000;
  localparam int TPP_NS = 3000;
  localparam int TE_NS = 20000;
  localparam int TW_CYC = TW_NS / CLK_NS;
  localparam int TPP_CYC = TPP_NS / CLK_NS;
  localparam int TE_CYC = TE_NS / CLK_NS;
  // Host serial clock half period in core cycles (80 ns period)
  localparam int HALF_CYC = 5;
  // Host register offsets
  localparam logic [3:0] RA_CMD = 4'h0;
  localparam logic [3:0] RA_STAT = 4'h4;
  localparam logic [3:0] RA_DATA = 4'h8;
endpackage

// *** sfsc_if.sv ***
// Interface carrying the serial flash link pins between host and device
`timescale 1ns/1ps
interface sfsc_if;
  logic cs_n; // Chip select, active low
  logic sclk; // Serial clock from host
  logic serial_in_line; // Host to device data
  logic so; // Device output line
  logic so_oe_n; // Device output enable, low while driving
  logic wp_n; // Write protect pin, active low
  // Host end drives the framing and input, device drives its output
  modport host (output cs_n, output sclk, output serial_in_line, output wp_n,
    input so, input so_oe_n);
  modport dev (input cs_n, input sclk, input serial_in_line, input wp_n,
    output so, output so_oe_n);
endinterface

// *** sfsc_sync.sv ***
// Two-stage synchroniser for a group of pins entering the core clock
`timescale 1ns/1ps
module sfsc_sync #(parameter int W = 4) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_r; // First stage, read only by second
  logic [W-1:0] s1_nxt;
  logic [W-1:0] s2_nxt;
  // Next values just shift along
  always_comb begin
    s1_nxt = din;
    s2_nxt = s1_r;
  end
  // Register both stages, reset to all ones (select, protect and output pins idle high)
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      s1_r <= '1;
      dout <= '1;
    end else begin
      s1_r <= s1_nxt;
      dout <= s2_nxt;
    end
  end
endmodule // sfsc_sync

// *** sfsc_dev.sv ***
// Serial flash device end: instruction decoder, status register and write cycle
// Operation
// - Opcode 06h sets write enable latch
// - Host enables writes before every write
// - Opcode 04h clears write enable latch
// - Latch cleared at reset and cycle end
// - Input bits sampled on rising clock
// - Status shifted out MSB first, falling edge
// - Status byte repeats until chip select
// - Status read accepted even while busy
// - Status write needs latch set first
// - Status write dropped unless byte aligned
// - Busy set for whole self-timed cycle
// - Latch cleared when status write ends
// - Protected areas refuse program and erase
// - Lock bit with low pin refuses status writes
// - All bytes move most significant first
// - Identity byte repeats until chip select, except JEDEC ID (three bytes only)
// - Busy device ignores all but status and identity reads
// - First byte after select is opcode
`timescale 1ns/1ps
module sfsc_dev
  import sfsc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  sfsc_if.dev link,
  output logic [7:0] status_out,
  output logic cycle_done
);
  // Synchronised pins: cs_n, sclk, data in, wp_n
  logic [3:0] pins;
  sfsc_sync #(.W(4)) u_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .din({link.cs_n, link.sclk, link.serial_in_line, link.wp_n}),
    .dout(pins)
  );
  logic cs_n_s, sclk_s, din_s, wp_n_s;
  assign cs_n_s = pins[3];
  assign sclk_s = pins[2];
  assign din_s = pins[1];
  assign wp_n_s = pins[0];

  typedef enum logic [1:0] {
    SFSC_IDLE = 2'b00,
    SFSC_BUSY = 2'b01
  } sfsc_cyc_e;

  // Address range check against protect bits on a 1MB map (16 blocks)
  function automatic logic prot_hit(input logic [7:0] sr, input logic [23:0] a);
    logic [2:0] bp;
    logic [3:0] blk;
    logic [4:0] n;
    begin
      bp = {sr[SB_BP2], sr[SB_BP1], sr[SB_BP0]};
      blk = a[19:16];
      n = 5'h00;
      prot_hit = 1'b0;
      if (bp >= 3'h5) begin
        prot_hit = 1'b1;
      end else if (bp != 3'h0) begin
        n = 5'(5'h01 << (bp - 3'h1)); // Blocks protected
        if (sr[SB_TB]) begin
          prot_hit = ({1'b0, blk} < n);
        end else begin
          prot_hit = ({1'b0, blk} >= (5'h10 - n));
        end
      end
    end
  endfunction

  logic sclk_d_r, sclk_d_nxt; // Previous sampled clock
  logic cs_d_r, cs_d_nxt; // Previous sampled select
  logic [7:0] sh_r, sh_nxt; // Input shift register
  logic [2:0] bit_r, bit_nxt; // Bit index in byte
  logic [2:0] byte_r, byte_nxt; // Bytes received, saturating
  logic [7:0] op_r, op_nxt; // Latched opcode
  logic [23:0] addr_r, addr_nxt; // Latched address
  logic [7:0] wdat_r, wdat_nxt; // Status write data byte
  logic pend_r, pend_nxt; // Program data seen
  logic [7:0] sr_r, sr_nxt; // Status register
  logic [7:0] osh_r, osh_nxt; // Output shift register
  logic so_r, so_nxt;
  logic oe_n_r, oe_n_nxt;
  sfsc_cyc_e cyc_r, cyc_nxt;
  logic [7:0] pend_sr_r, pend_sr_nxt; // Value applied at cycle end
  logic [12:0] cnt_r, cnt_nxt; // Self-timed cycle counter
  logic done_r, done_nxt;

  logic rise, fall, cs_rise, cs_fall;
  logic [7:0] byte_in;
  logic byte_end;
  assign rise = sclk_s & ~sclk_d_r;
  assign fall = ~sclk_s & sclk_d_r;
  assign cs_fall = ~cs_n_s & cs_d_r;
  assign cs_rise = cs_n_s & ~cs_d_r;
  assign byte_in = {sh_r[6:0], din_s};
  assign byte_end = rise & ~cs_n_s & (bit_r == 3'h7);

  // Serial front end, decoder, status and write cycle
  always_comb begin
    sclk_d_nxt = sclk_s;
    cs_d_nxt = cs_n_s;
    sh_nxt = sh_r;
    bit_nxt = bit_r;
    byte_nxt = byte_r;
    op_nxt = op_r;
    addr_nxt = addr_r;
    wdat_nxt = wdat_r;
    pend_nxt = pend_r;
    sr_nxt = sr_r;
    osh_nxt = osh_r;
    so_nxt = so_r;
    oe_n_nxt = oe_n_r;
    cyc_nxt = cyc_r;
    pend_sr_nxt = pend_sr_r;
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    if (cs_fall) begin
      // New frame, first byte will be the opcode
      bit_nxt = 3'h0;
      byte_nxt = 3'h0;
      pend_nxt = 1'b0;
      op_nxt = 8'h00;
    end
    if (rise & ~cs_n_s) begin
      sh_nxt = byte_in;
      bit_nxt = 3'(bit_r + 3'h1);
    end
    if (byte_end) begin
      if (byte_r != 3'h7) begin
        byte_nxt = 3'(byte_r + 3'h1);
      end
      if (byte_r == 3'h0) begin
        op_nxt = byte_in;
        // Status and JEDEC ID reads preload the byte to return
        case (byte_in)
          OP_RDSR: osh_nxt = sr_r;
          OP_JEDID: osh_nxt = ID_MFR;
          default: osh_nxt = 8'h00;
        endcase
      end else if (byte_r <= 3'h3) begin
        addr_nxt = {addr_r[15:0], byte_in};
        if (op_r == OP_WRSR && byte_r == 3'h1) begin
          wdat_nxt = byte_in;
        end
        if (byte_r == 3'h3 && op_r == OP_RELID) begin
          osh_nxt = ID_DEV;
        end
        if (byte_r == 3'h3 && op_r == OP_MFID) begin
          osh_nxt = ID_MFR;
        end
        if (byte_r == 3'h1 && op_r == OP_JEDID) begin
          osh_nxt = ID_TYPE;
        end
        if (byte_r == 3'h2 && op_r == OP_JEDID) begin
          osh_nxt = ID_DEV;
        end
      end else if (op_r == OP_PROG) begin
        pend_nxt = 1'b1;
      end
    end
    // Output shifting on falling edges, status and MFID bytes reload each eight bits
    if (fall & ~cs_n_s) begin
      if (op_r == OP_RDSR && byte_r != 3'h0) begin
        so_nxt = osh_r[3'h7 - bit_r];
        oe_n_nxt = 1'b0;
        if (bit_r == 3'h7) begin
          osh_nxt = sr_r;
        end
      end else if (op_r == OP_RELID && byte_r >= 3'h4) begin
        so_nxt = osh_r[3'h7 - bit_r];
        oe_n_nxt = 1'b0;
      end else if ((op_r == OP_MFID && byte_r >= 3'h4) ||
          (op_r == OP_JEDID && byte_r >= 3'h1 && byte_r <= 3'h3)) begin
        so_nxt = osh_r[3'h7 - bit_r];
        oe_n_nxt = 1'b0;
        if (bit_r == 3'h7 && op_r == OP_MFID) begin
          osh_nxt = ID_DEV;
        end
      end
    end
    if (cs_n_s) begin
      oe_n_nxt = 1'b1;
    end
    // End of frame: execute write type instructions
    if (cs_rise && cyc_r == SFSC_IDLE && bit_r == 3'h0) begin
      case (op_r)
        OP_WREN: if (byte_r == 3'h1) sr_nxt[SB_WEL] = 1'b1;
        OP_WRDI: if (byte_r == 3'h1) sr_nxt[SB_WEL] = 1'b0;
        OP_WRSR: begin
          if (byte_r == 3'h2 && sr_r[SB_WEL] &&
              !(sr_r[SB_SRP] && !wp_n_s)) begin
            pend_sr_nxt = (sr_r & ~SR_WMASK) | (wdat_r & SR_WMASK);
            cnt_nxt = 13'(TW_CYC);
            cyc_nxt = SFSC_BUSY;
            sr_nxt[SB_BUSY] = 1'b1;
          end
        end
        OP_PROG: begin
          if (pend_r && sr_r[SB_WEL] && !prot_hit(sr_r, addr_r)) begin
            pend_sr_nxt = sr_r;
            cnt_nxt = 13'(TPP_CYC);
            cyc_nxt = SFSC_BUSY;
            sr_nxt[SB_BUSY] = 1'b1;
          end
        end
        OP_SERASE, OP_BERASE: begin
          if (byte_r == 3'h4 && sr_r[SB_WEL] && !prot_hit(sr_r, addr_r)) begin
            pend_sr_nxt = sr_r;
            cnt_nxt = 13'(TE_CYC);
            cyc_nxt = SFSC_BUSY;
            sr_nxt[SB_BUSY] = 1'b1;
          end
        end
        OP_CERASE: begin
          if (byte_r == 3'h1 && sr_r[SB_WEL] &&
              {sr_r[SB_BP2], sr_r[SB_BP1], sr_r[SB_BP0]} == 3'h0) begin
            pend_sr_nxt = sr_r;
            cnt_nxt = 13'(TE_CYC);
            cyc_nxt = SFSC_BUSY;
            sr_nxt[SB_BUSY] = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // Self-timed cycle countdown
    case (cyc_r)
      SFSC_BUSY: begin
        if (cnt_r <= 13'h0001) begin
          sr_nxt = pend_sr_r;
          sr_nxt[SB_BUSY] = 1'b0;
          sr_nxt[SB_WEL] = 1'b0;
          cyc_nxt = SFSC_IDLE;
          done_nxt = 1'b1;
        end else begin
          cnt_nxt = 13'(cnt_r - 13'h0001);
        end
      end
      default: ;
    endcase
  end

  // Register all device state
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sclk_d_r <= 1'b1;
      cs_d_r <= 1'b1;
      sh_r <= 8'h00;
      bit_r <= 3'h0;
      byte_r <= 3'h0;
      op_r <= 8'h00;
      addr_r <= 24'h000000;
      wdat_r <= 8'h00;
      pend_r <= 1'b0;
      sr_r <= SR_RESET;
      osh_r <= 8'h00;
      so_r <= 1'b1;
      oe_n_r <= 1'b1;
      cyc_r <= SFSC_IDLE;
      pend_sr_r <= SR_RESET;
      cnt_r <= 13'h0000;
      done_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_d_nxt;
      cs_d_r <= cs_d_nxt;
      sh_r <= sh_nxt;
      bit_r <= bit_nxt;
      byte_r <= byte_nxt;
      op_r <= op_nxt;
      addr_r <= addr_nxt;
      wdat_r <= wdat_nxt;
      pend_r <= pend_nxt;
      sr_r <= sr_nxt;
      osh_r <= osh_nxt;
      so_r <= so_nxt;
      oe_n_r <= oe_n_nxt;
      cyc_r <= cyc_nxt;
      pend_sr_r <= pend_sr_nxt;
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign link.so = so_r;
  assign link.so_oe_n = oe_n_r;
  assign status_out = sr_r;
  assign cycle_done = done_r;
endmodule // sfsc_dev

// *** sfsc_host.sv ***
// Host end: AXI4-Lite slave registers that drive serial frames to the flash
`timescale 1ns/1ps
module sfsc_host
  import sfsc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  sfsc_if.host link,
  input wire logic [3:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [3:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);
  // Synchronised device output
  logic [0:0] so_s;
  sfsc_sync #(.W(1)) u_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .din(link.so),
    .dout(so_s)
  );
  logic aw_r, aw_nxt, w_r, w_nxt; // Address/data taken flags
  logic [3:0] awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt;
  logic awrdy_r, awrdy_nxt, wrdy_r, wrdy_nxt, bv_r, bv_nxt;
  logic ardy_r, ardy_nxt, rv_r, rv_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
  logic busy_r, busy_nxt; // Frame running
  logic [2:0] nbytes_r, nbytes_nxt; // Bytes left in frame
  logic [31:0] tx_r, tx_nxt; // Bytes to send, MSB first
  logic [7:0] rx_r, rx_nxt; // Last received byte
  logic [2:0] bit_r, bit_nxt;
  logic [2:0] hc_r, hc_nxt; // Half period counter
  logic sclk_r, sclk_nxt, cs_n_r, cs_n_nxt, mosi_r, mosi_nxt, wp_n_r, wp_n_nxt;
  logic wr_go;
  assign wr_go = aw_r & w_r & ~bv_r;

  // Bus channels plus the serial engine
  always_comb begin
    aw_nxt = aw_r; w_nxt = w_r; awa_nxt = awa_r; wd_nxt = wd_r;
    awrdy_nxt = ~aw_r & ~bv_r; wrdy_nxt = ~w_r & ~bv_r;
    bv_nxt = bv_r; br_nxt = br_r;
    ardy_nxt = ~rv_r; rv_nxt = rv_r; rd_nxt = rd_r; rr_nxt = rr_r;
    busy_nxt = busy_r; nbytes_nxt = nbytes_r; tx_nxt = tx_r; rx_nxt = rx_r;
    bit_nxt = bit_r; hc_nxt = hc_r; sclk_nxt = sclk_r; cs_n_nxt = cs_n_r;
    mosi_nxt = mosi_r; wp_n_nxt = wp_n_r;
    if (s_awvalid && awrdy_r) begin
      aw_nxt = 1'b1; awa_nxt = s_awaddr; awrdy_nxt = 1'b0;
    end
    if (s_wvalid && wrdy_r) begin
      w_nxt = 1'b1; wd_nxt = s_wdata; wrdy_nxt = 1'b0;
    end
    if (wr_go) begin
      aw_nxt = 1'b0; w_nxt = 1'b0; bv_nxt = 1'b1; br_nxt = 2'b00;
      if (awa_r == RA_CMD && !busy_r) begin
        // wdata[2:0] byte count, [3] wp level, [31:8] bytes MSB first
        busy_nxt = 1'b1; nbytes_nxt = wd_r[2:0]; wp_n_nxt = wd_r[3];
        tx_nxt = {wd_r[31:8], 8'h00}; cs_n_nxt = 1'b0; bit_nxt = 3'h0;
        mosi_nxt = wd_r[31]; hc_nxt = 3'h0;
      end else if (awa_r != RA_CMD) begin
        br_nxt = 2'b10;
      end
    end
    if (bv_r && s_bready) bv_nxt = 1'b0;
    if (s_arvalid && ardy_r) begin
      rv_nxt = 1'b1; ardy_nxt = 1'b0; rr_nxt = 2'b00;
      case (s_araddr)
        RA_STAT: rd_nxt = {31'h0, busy_r};
        RA_DATA: rd_nxt = {24'h0, rx_r};
        default: begin rd_nxt = 32'h0; rr_nxt = 2'b10; end
      endcase
    end
    if (rv_r && s_rready) rv_nxt = 1'b0;
    // Serial engine, 80 ns clock from divider
    if (busy_r) begin
      if (nbytes_r == 3'h0) begin
        cs_n_nxt = 1'b1; busy_nxt = 1'b0; sclk_nxt = 1'b0;
      end else if (hc_r == 3'(HALF_CYC - 1)) begin
        hc_nxt = 3'h0;
        sclk_nxt = ~sclk_r;
        if (sclk_r) begin
          // Sample as the clock falls: the round trip through both
          // synchronisers outlasts half a serial clock period
          rx_nxt = {rx_r[6:0], so_s[0]};
          bit_nxt = 3'(bit_r + 3'h1);
          tx_nxt = {tx_r[30:0], 1'b0};
          mosi_nxt = tx_r[30];
          if (bit_r == 3'h7) nbytes_nxt = 3'(nbytes_r - 3'h1);
        end
      end else begin
        hc_nxt = 3'(hc_r + 3'h1);
      end
    end
  end

  // Register host state
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      aw_r <= 1'b0; w_r <= 1'b0; awa_r <= 4'h0; wd_r <= 32'h0;
      awrdy_r <= 1'b0; wrdy_r <= 1'b0; bv_r <= 1'b0; br_r <= 2'b00;
      ardy_r <= 1'b0; rv_r <= 1'b0; rd_r <= 32'h0; rr_r <= 2'b00;
      busy_r <= 1'b0; nbytes_r <= 3'h0; tx_r <= 32'h0; rx_r <= 8'h00;
      bit_r <= 3'h0; hc_r <= 3'h0; sclk_r <= 1'b0; cs_n_r <= 1'b1;
      mosi_r <= 1'b0; wp_n_r <= 1'b1;
    end else begin
      aw_r <= aw_nxt; w_r <= w_nxt; awa_r <= awa_nxt; wd_r <= wd_nxt;
      awrdy_r <= awrdy_nxt; wrdy_r <= wrdy_nxt; bv_r <= bv_nxt; br_r <= br_nxt;
      ardy_r <= ardy_nxt; rv_r <= rv_nxt; rd_r <= rd_nxt; rr_r <= rr_nxt;
      busy_r <= busy_nxt; nbytes_r <= nbytes_nxt; tx_r <= tx_nxt; rx_r <= rx_nxt;
      bit_r <= bit_nxt; hc_r <= hc_nxt; sclk_r <= sclk_nxt; cs_n_r <= cs_n_nxt;
      mosi_r <= mosi_nxt; wp_n_r <= wp_n_nxt;
    end
  end

  assign link.cs_n = cs_n_r;
  assign link.sclk = sclk_r;
  assign link.serial_in_line = mosi_r;
  assign link.wp_n = wp_n_r;
  assign s_awready = awrdy_r;
  assign s_wready = wrdy_r;
  assign s_bvalid = bv_r;
  assign s_bresp = br_r;
  assign s_arready = ardy_r;
  assign s_rvalid = rv_r;
  assign s_rdata = rd_r;
  assign s_rresp = rr_r;
endmodule // sfsc_host

// *** sfsc_chk.sv ***
// Concurrent checks on the serial flash link pins between host and device ends
`timescale 1ns/1ps
module sfsc_chk (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_in_line,
  input wire logic so,
  input wire logic so_oe_n,
  input wire logic wp_n
);
  logic [2:0] bits_r; // Serial clock rises in the current frame, modulo eight
  logic [2:0] bits_nxt; // Next value of the rise counter
  logic sclk_q_r; // Serial clock one core cycle ago
  logic sclk_q_nxt; // Next value of the delayed serial clock

  // Count serial clock rises while selected, clear while deselected
  always_comb begin
    sclk_q_nxt = sclk;
    bits_nxt = bits_r;
    if (cs_n) begin
      bits_nxt = 3'h0;
    end else if (sclk && !sclk_q_r) begin
      bits_nxt = bits_r + 3'h1;
    end
  end

  // Register the counter state
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      bits_r <= 3'h0;
      sclk_q_r <= 1'b0;
    end else begin
      bits_r <= bits_nxt;
      sclk_q_r <= sclk_q_nxt;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sclk_idle_a: assert property (cs_n |-> !sclk)
    else $error("serial clock high while deselected");
  cs_fall_a: assert property ($fell(cs_n) |-> !sclk [*2])
    else $error("frame opened without clock low setup");
  whole_byte_a: assert property ($rose(cs_n) |-> bits_r == 3'h0 && !$past(sclk))
    else $error("frame closed off a byte boundary");
  din_hold_a: assert property ($rose(sclk) |-> $stable(serial_in_line) [*3])
    else $error("input line moved around a rising clock");
  sclk_high_a: assert property ($rose(sclk) |-> sclk [*5] ##1 !sclk)
    else $error("serial clock high time wrong");
  sclk_low_a: assert property ($fell(sclk) |-> !sclk [*5])
    else $error("serial clock low time too short");
  dout_hold_a: assert property ($rose(sclk) && !so_oe_n |-> ($stable(so) || so_oe_n) [*4])
    else $error("output line moved near a rising clock");
  dout_release_a: assert property (cs_n [*8] |-> so_oe_n)
    else $error("output driven while deselected");
endmodule // sfsc_chk

// *** sfsc_tb.sv ***
// Testbench joining host and device ends and driving the host registers
`timescale 1ns/1ps
module sfsc_tb
  import sfsc_pkg::*;
;
  logic core_clk; // Core clock
  logic reset_n; // Synchronous reset, active low
  logic [3:0] s_awaddr, s_araddr; // Register addresses
  logic s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready; // Master handshakes
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid; // Slave handshakes
  logic [31:0] s_wdata, s_rdata; // Register data
  logic [3:0] s_wstrb; // Byte strobes
  logic [1:0] s_bresp, s_rresp; // Responses
  logic [7:0] status_out; // Device status byte
  logic cycle_done; // End of a self-timed cycle
  int n_fail; // Mismatches seen
  int n_compared; // Comparisons made
  int busy_len; // Length of the last busy stretch in core cycles
  logic busy_q; // Busy bit one cycle ago
  logic [31:0] rd; // Last read data
  logic [7:0] st; // Last status byte read over the link

  sfsc_if sfsc_if_inst ();
  sfsc_host sfsc_host_inst (.core_clk(core_clk), .reset_n(reset_n), .link(sfsc_if_inst),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready));
  sfsc_dev sfsc_dev_inst (.core_clk(core_clk), .reset_n(reset_n), .link(sfsc_if_inst),
    .status_out(status_out), .cycle_done(cycle_done));
  sfsc_chk sfsc_chk_inst (.core_clk(core_clk), .reset_n(reset_n), .cs_n(sfsc_if_inst.cs_n),
    .sclk(sfsc_if_inst.sclk), .serial_in_line(sfsc_if_inst.serial_in_line),
    .so(sfsc_if_inst.so), .so_oe_n(sfsc_if_inst.so_oe_n), .wp_n(sfsc_if_inst.wp_n));

  // Core clock, 8 ns period
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Measure how long the busy bit stays up
  always @(posedge core_clk) begin
    busy_q <= status_out[SB_BUSY];
    if (status_out[SB_BUSY] === 1'b1 && busy_q !== 1'b1) begin
      busy_len <= 1;
    end else if (status_out[SB_BUSY] === 1'b1) begin
      busy_len <= busy_len + 1;
    end
  end

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // Print counts and the verdict, then stop
  task automatic close_out();
    $display("compared %0d, mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // A bounded wait ran out
  task automatic hang();
    n_fail++;
    $display("MISMATCH at %0t: wait ran out", $time);
    close_out();
  endtask

  // One register write, address and data offered together
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] exp);
    int k;
    @(posedge core_clk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge core_clk);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
      if (s_bvalid === 1'b1) break;
    end
    if (k == 100) hang();
    s_bready <= 1'b0;
    check(32'(s_bresp), 32'(exp), "write response");
  endtask

  // One register read
  task automatic axi_rd(input logic [3:0] a, input logic [1:0] exp, output logic [31:0] d);
    int k;
    @(posedge core_clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge core_clk);
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
      if (s_rvalid === 1'b1) break;
    end
    if (k == 100) hang();
    s_rready <= 1'b0;
    d = s_rdata;
    check(32'(s_rresp), 32'(exp), "read response");
  endtask

  // Command word: first two bytes, write protect level, byte count
  function automatic logic [31:0] mk(input logic [7:0] op, input logic [7:0] b2,
    input logic wp, input logic [2:0] cnt);
    return {op, b2, 8'h00, 4'h0, wp, cnt};
  endfunction

  // Send one frame and wait until the host reports it finished
  task automatic frame(input logic [31:0] cmd);
    int k;
    axi_wr(RA_CMD, cmd, 2'b00);
    for (k = 0; k < 200; k++) begin
      axi_rd(RA_STAT, 2'b00, rd);
      if (rd[0] === 1'b0) break;
    end
    if (k == 200) hang();
  endtask

  // Status read over three repeated bytes, returns the last one
  task automatic rd_status(output logic [7:0] s);
    frame(mk(OP_RDSR, 8'h00, 1'b1, 3'h4));
    axi_rd(RA_DATA, 2'b00, rd);
    s = rd[7:0];
  endtask

  // Single byte instruction with write protect high
  task automatic cmd1(input logic [7:0] op);
    frame(mk(op, 8'h00, 1'b1, 3'h1));
  endtask

  // Wait for the end of a self-timed cycle
  task automatic wait_done();
    int k;
    for (k = 0; k < 4000; k++) begin
      @(posedge core_clk);
      if (cycle_done === 1'b1) break;
    end
    if (k == 4000) hang();
  endtask

  // Status after reset is clear
  task automatic t_reset();
    check(32'(status_out), 32'(SR_RESET), "status after reset");
    rd_status(st);
    check(32'(st), 32'h0, "status read after reset");
    $display("test reset done");
  endtask

  // Latch set and clear
  task automatic t_latch();
    cmd1(OP_WREN);
    rd_status(st);
    check(32'(st), 32'h02, "latch after enable");
    cmd1(OP_WRDI);
    rd_status(st);
    check(32'(st), 32'h00, "latch after disable");
    $display("test latch done");
  endtask

  // Status writes without latch or with an extra byte are dropped
  task automatic t_guard();
    frame(mk(OP_WRSR, 8'hbc, 1'b1, 3'h2));
    rd_status(st);
    check(32'(st), 32'h00, "write without latch");
    cmd1(OP_WREN);
    frame(mk(OP_WRSR, 8'hbc, 1'b1, 3'h3));
    rd_status(st);
    check(32'(st), 32'h02, "overlong status write");
    cmd1(OP_WRDI);
    $display("test guard done");
  endtask

  // Self-timed status write, polled while busy, then protected erase
  task automatic t_cycle();
    cmd1(OP_WREN);
    frame(mk(OP_WRSR, 8'hff, 1'b1, 3'h2));
    cmd1(OP_WRDI);
    rd_status(st);
    check(32'(st & 8'h03), 32'h03, "busy and latch during cycle");
    wait_done();
    @(posedge core_clk);
    check(32'(status_out), 32'hbc, "status after cycle");
    check(32'(busy_len >= TW_CYC - 2 && busy_len <= TW_CYC + 2), 32'h1, "busy time");
    cmd1(OP_WREN);
    cmd1(OP_CERASE);
    rd_status(st);
    check(32'(st), 32'hbe, "erase of protected array");
    $display("test cycle done");
  endtask

  // Lock bit with the protect pin low refuses, high allows, then an open sector erase
  task automatic t_lock();
    frame(mk(OP_WRSR, 8'h00, 1'b0, 3'h2));
    rd_status(st);
    check(32'(st & 8'hbd), 32'hbc, "locked status write");
    cmd1(OP_WREN);
    frame(mk(OP_WRSR, 8'h00, 1'b1, 3'h2));
    wait_done();
    @(posedge core_clk);
    check(32'(status_out), 32'h00, "unlocked status write");
    cmd1(OP_WREN);
    frame(mk(OP_SERASE, 8'h00, 1'b1, 3'h4));
    wait_done();
    @(posedge core_clk);
    check(32'(status_out), 32'h00, "latch after erase");
    check(32'(busy_len >= TE_CYC - 2 && busy_len <= TE_CYC + 2), 32'h1, "erase time");
    $display("test lock done");
  endtask

  // Identity bytes, repeated where the layout repeats them
  task automatic t_ident();
    logic [7:0] ops [3] = '{OP_RELID, OP_MFID, OP_JEDID};
    logic [2:0] cnt [3] = '{3'h7, 3'h6, 3'h2};
    logic [7:0] idv [3] = '{ID_DEV, ID_DEV, ID_MFR};
    for (int i = 0; i < 3; i++) begin
      frame(mk(ops[i], 8'h00, 1'b1, cnt[i]));
      axi_rd(RA_DATA, 2'b00, rd);
      check(32'(rd[7:0]), 32'(idv[i]), "identity byte");
    end
    $display("test ident done");
  endtask

  // Unmapped register address is refused
  task automatic t_bus();
    axi_rd(4'hc, 2'b10, rd);
    axi_wr(4'hc, 32'h0000_0000, 2'b10);
    $display("test bus done");
  endtask

  // Main sequence
  initial begin
    {s_awaddr, s_araddr, s_wdata} = '0;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    s_wstrb = 4'hf;
    reset_n = 1'b0;
    n_fail = 0;
    n_compared = 0;
    busy_len = 0;
    busy_q = 1'b0;
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    t_reset();
    t_latch();
    t_guard();
    t_cycle();
    t_lock();
    t_ident();
    t_bus();
    close_out();
  end
endmodule // sfsc_tb
